// >>> hdl/mgmt_mode_consts.vh
/*
 constants for the management mode save-area control block.
 assumes inclusion by bare name from hdl/ sources.
*/
`ifndef MGMT_MODE_CONSTS_VH
`define MGMT_MODE_CONSTS_VH
// ==========================================================
// save-area offsets (relative to the save-area base)
`define OFS_SAVE_AREA_BASE 32'h00007ef8
`define OFS_REVISION_WORD 32'h00007efc
`define OFS_IO_RESTART 32'h00007f00
`define OFS_HALT_RESTART 32'h00007f02
// ==========================================================
// revision word fields
`define REV_IO_RESTART_BIT 16
`define REV_RELOC_BIT 17
`define REV_BASE_VERSION 16'h0001
// ==========================================================
// reset values, field codes, handler entry address and segment shift
`define RST_SAVE_AREA_BASE 32'h00030000
`define IO_RESTART_CLEAR 8'h00
`define IO_RESTART_REDO 8'hff
`define HALT_RESTART_BIT 0
`define HANDLER_ENTRY_IP 32'h00008000
`define SEG_SHIFT 4
`endif

// >>> hdl/save_area_writer.v
/*
 save_area_writer: serialises the entry-time writes into the save area.
 assumes the memory port accepts one write per cycle while mem_ready is high.
*/
`include "mgmt_mode_consts.vh"
`default_nettype none
module save_area_writer (
   // clock and reset
   input wire core_clk,
   input wire srst,
   // control
   input wire start,
   input wire [31:0] base,
   input wire [31:0] revision,
   input wire halted_at_entry,
   output reg done,
   // memory write port
   output reg mem_we,
   output reg [31:0] mem_addr,
   output reg [31:0] mem_wdata,
   input wire mem_ready
);
   // ==========================================================
   // write sequencer
   localparam S_IDLE = 2'd0;
   localparam S_REV = 2'd1;
   localparam S_IO = 2'd2;
   localparam S_HALT = 2'd3;
   reg [1:0] state_q;

   always @(posedge core_clk) begin
      if (srst) begin
         state_q <= S_IDLE;
         done <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 32'h00000000;
         mem_wdata <= 32'h00000000;
      end else begin
         done <= 1'b0;
         case (state_q)
            S_IDLE: begin
               mem_we <= 1'b0;
               if (start) begin
                  state_q <= S_REV;
                  mem_we <= 1'b1;
                  mem_addr <= base + `OFS_REVISION_WORD;
                  mem_wdata <= revision;
               end
            end
            S_REV: begin
               if (mem_ready) begin
                  state_q <= S_IO;
                  mem_addr <= base + `OFS_IO_RESTART;
                  mem_wdata <= {24'h000000, `IO_RESTART_CLEAR};
               end
            end
            S_IO: begin
               if (mem_ready) begin
                  state_q <= S_HALT;
                  mem_addr <= base + `OFS_HALT_RESTART;
                  mem_wdata <= {31'h00000000, halted_at_entry};
               end
            end
            S_HALT: begin
               if (mem_ready) begin
                  state_q <= S_IDLE;
                  mem_we <= 1'b0;
                  done <= 1'b1;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> hdl/mgmt_mode_save_area_control.v
/*
 mgmt_mode_save_area_control: management mode entry/resume control.
 assumes the core reports halt state, resume, and save-area fields read back
 by the handler; interrupt pin is asynchronous, controller message is core-clock.
*/
`include "mgmt_mode_consts.vh"
`default_nettype none
module mgmt_mode_save_area_control #(
   parameter IO_RESTART_SUPPORTED = 1,
   parameter RELOC_SUPPORTED = 1
) (
   // clock and reset
   input wire core_clk,
   input wire srst,
   input wire soft_init,
   // interrupt sources
   input wire mgmt_interrupt_pin_n,
   input wire mgmt_interrupt_msg,
   input wire nmi_req,
   input wire maskable_irq,
   // core status
   input wire core_halted,
   input wire resume_req,
   input wire [31:0] saved_base_field,
   input wire [7:0] io_restart_field,
   input wire [15:0] halt_restart_field,
   input wire [15:0] seg_selector,
   input wire [31:0] trapped_io_ip,
   input wire [31:0] next_io_ip,
   // save-area memory port
   output wire mem_we,
   output wire [31:0] mem_addr,
   output wire [31:0] mem_wdata,
   input wire mem_ready,
   // core control
   output reg in_mgmt_mode_q,
   output reg [31:0] save_area_base_q,
   output reg [15:0] code_seg_q,
   output reg [31:0] instruction_pointer_q,
   output reg [31:0] seg_base_q,
   output reg ip_load_q,
   output reg reenter_halt_q,
   output reg refetch_halt_q,
   output reg halt_bus_cycle_q,
   output reg wake_from_halt_q,
   output reg nmi_service_q,
   output reg [31:0] revision_word_q
);
   // ==========================================================
   // revision word
   function [31:0] make_revision;
      input io_ok;
      input reloc_ok;
      begin
         make_revision = {14'h0000, reloc_ok, io_ok, `REV_BASE_VERSION};
      end
   endfunction

   wire [31:0] revision_d = make_revision(IO_RESTART_SUPPORTED != 0,
                                          RELOC_SUPPORTED != 0);

   // ==========================================================
   // input synchronisers and request detection
   reg pin_s1_q;
   reg pin_s2_q;
   reg pin_s3_q;
   always @(posedge core_clk) begin
      if (srst) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= ~mgmt_interrupt_pin_n;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end
   wire pin_edge = pin_s2_q & ~pin_s3_q;
   wire mgmt_interrupt = pin_edge | mgmt_interrupt_msg;

   // ==========================================================
   // sequencer
   localparam S_RUN = 3'd0;
   localparam S_ENTRY = 3'd1;
   localparam S_HANDLER = 3'd2;
   localparam S_HALT_IN = 3'd3;
   localparam S_RESUME = 3'd4;
   reg [2:0] state_q;
   reg pending_q;
   reg halted_at_entry_q;
   reg nmi_latched_q;
   reg start_write_q;
   wire write_done;

   save_area_writer u_writer (
      .core_clk(core_clk),
      .srst(srst),
      .start(start_write_q),
      .base(save_area_base_q),
      .revision(revision_word_q),
      .halted_at_entry(halted_at_entry_q),
      .done(write_done),
      .mem_we(mem_we),
      .mem_addr(mem_addr),
      .mem_wdata(mem_wdata),
      .mem_ready(mem_ready)
   );

   // base register survives soft init: only srst and the resume state load it
   always @(posedge core_clk) begin
      if (srst) begin
         save_area_base_q <= `RST_SAVE_AREA_BASE;
      end else if (state_q == S_RESUME) begin
         // no alignment mask: overlapping regions need arbitrary bases
         save_area_base_q <= saved_base_field;
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         state_q <= S_RUN;
         pending_q <= 1'b0;
         halted_at_entry_q <= 1'b0;
         nmi_latched_q <= 1'b0;
         start_write_q <= 1'b0;
         in_mgmt_mode_q <= 1'b0;
         code_seg_q <= 16'h0000;
         instruction_pointer_q <= 32'h00000000;
         seg_base_q <= 32'h00000000;
         ip_load_q <= 1'b0;
         reenter_halt_q <= 1'b0;
         refetch_halt_q <= 1'b0;
         halt_bus_cycle_q <= 1'b0;
         wake_from_halt_q <= 1'b0;
         nmi_service_q <= 1'b0;
         revision_word_q <= 32'h00000000;
      end else begin
         start_write_q <= 1'b0;
         ip_load_q <= 1'b0;
         refetch_halt_q <= 1'b0;
         halt_bus_cycle_q <= 1'b0;
         wake_from_halt_q <= 1'b0;
         nmi_service_q <= 1'b0;
         revision_word_q <= revision_d;
         // segment loads inside the mode use real-mode style bases
         seg_base_q <= {12'h000, seg_selector, 4'h0};
         // nmi is held off in the mode; a second request merges into one
         if (in_mgmt_mode_q && nmi_req)
            nmi_latched_q <= 1'b1;
         // one request arriving during the mode is remembered, not lost
         if (in_mgmt_mode_q && mgmt_interrupt)
            pending_q <= 1'b1;
         if (soft_init && !in_mgmt_mode_q)
            reenter_halt_q <= 1'b0;
         case (state_q)
            S_RUN: begin
               if (nmi_latched_q) begin
                  nmi_service_q <= 1'b1;
                  nmi_latched_q <= 1'b0;
                  // a request that meets the nmi slot waits; dropping it would lose a pulse
                  if (mgmt_interrupt)
                     pending_q <= 1'b1;
               end else if (mgmt_interrupt || pending_q) begin
                  pending_q <= 1'b0;
                  halted_at_entry_q <= core_halted;
                  reenter_halt_q <= 1'b0;
                  in_mgmt_mode_q <= 1'b1;
                  start_write_q <= 1'b1;
                  state_q <= S_ENTRY;
               end
            end
            S_ENTRY: begin
               if (write_done) begin
                  code_seg_q <= save_area_base_q[`SEG_SHIFT+15:`SEG_SHIFT];
                  instruction_pointer_q <= `HANDLER_ENTRY_IP;
                  ip_load_q <= 1'b1;
                  state_q <= S_HANDLER;
               end
            end
            S_HANDLER: begin
               if (resume_req)
                  state_q <= S_RESUME;
               else if (core_halted)
                  state_q <= S_HALT_IN;
            end
            S_HALT_IN: begin
               // only a maskable interrupt or hardware reset leaves this
               if (maskable_irq) begin
                  wake_from_halt_q <= 1'b1;
                  state_q <= S_HANDLER;
               end
            end
            S_RESUME: begin
               in_mgmt_mode_q <= 1'b0;
               state_q <= S_RUN;
               // a halt bit set by the handler is ignored unless the core was halted at entry
               if (halted_at_entry_q &&
                   halt_restart_field[`HALT_RESTART_BIT]) begin
                  reenter_halt_q <= 1'b1;
                  refetch_halt_q <= 1'b1;
                  halt_bus_cycle_q <= 1'b1;
               end
               if (io_restart_field == `IO_RESTART_REDO && IO_RESTART_SUPPORTED != 0) begin
                  instruction_pointer_q <= trapped_io_ip;
                  ip_load_q <= 1'b1;
               end else if (io_restart_field == `IO_RESTART_CLEAR) begin
                  instruction_pointer_q <= next_io_ip;
                  ip_load_q <= 1'b1;
               end
               // clear halt bit or no halt: core continues in order
               if (!halt_restart_field[`HALT_RESTART_BIT])
                  reenter_halt_q <= 1'b0;
            end
            default: state_q <= S_RUN;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> bench/mgmt_chk_assertions.sv
/*
 checker for the management mode save-area control block.
 assumes one core clock domain; bound to the top module's ports.
*/
`default_nettype none
module mgmt_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // inputs watched
   input wire logic soft_init,
   input wire logic [15:0] seg_selector,
   input wire logic [31:0] saved_base_field,
   // outputs watched
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic in_mgmt_mode_q,
   input wire logic [31:0] save_area_base_q,
   input wire logic [15:0] code_seg_q,
   input wire logic [31:0] instruction_pointer_q,
   input wire logic [31:0] seg_base_q,
   input wire logic ip_load_q,
   input wire logic nmi_service_q,
   input wire logic [31:0] revision_word_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // ==========================================================
   // entry
   sequence s_enter; $rose(in_mgmt_mode_q); endsequence
   sequence s_rev_wr; mem_we && mem_addr == save_area_base_q + 32'h00007efc; endsequence
   property p_rev; !$past(srst) |-> revision_word_q == 32'h00030001; endproperty
   a_rev: assert property (p_rev) else $error("revision word wrong");
   property p_wr; s_enter |-> ##[1:2] s_rev_wr ##0 mem_wdata == revision_word_q; endproperty
   a_wr: assert property (p_wr) else $error("revision not written");
   property p_io; mem_we && mem_addr == save_area_base_q + 32'h00007f00 |->
      mem_wdata == 32'h00000000;
   endproperty
   a_io: assert property (p_io) else $error("io field not cleared");
   property p_ip; $rose(ip_load_q) && in_mgmt_mode_q |->
      instruction_pointer_q == 32'h00008000 && code_seg_q == save_area_base_q[19:4];
   endproperty
   a_ip: assert property (p_ip) else $error("handler start wrong");
   // ==========================================================
   // steady state and resume
   property p_seg; !$past(srst) |-> seg_base_q == {12'h000, $past(seg_selector), 4'h0};
   endproperty
   a_seg: assert property (p_seg) else $error("segment base wrong");
   property p_reload; $fell(in_mgmt_mode_q) && !$past(srst) |->
      save_area_base_q == $past(saved_base_field);
   endproperty
   a_reload: assert property (p_reload) else $error("base not reloaded");
   property p_nmi; nmi_service_q |-> !in_mgmt_mode_q; endproperty
   a_nmi: assert property (p_nmi) else $error("nmi served in mode");
   property p_init; soft_init && !in_mgmt_mode_q |=> $stable(save_area_base_q); endproperty
   a_init: assert property (p_init) else $error("base lost on init");
endmodule
bind mgmt_mode_save_area_control mgmt_chk chk_u (
   .core_clk(core_clk), .srst(srst), .soft_init(soft_init), .seg_selector(seg_selector),
   .saved_base_field(saved_base_field), .mem_we(mem_we), .mem_addr(mem_addr),
   .mem_wdata(mem_wdata), .in_mgmt_mode_q(in_mgmt_mode_q),
   .save_area_base_q(save_area_base_q), .code_seg_q(code_seg_q),
   .instruction_pointer_q(instruction_pointer_q), .seg_base_q(seg_base_q),
   .ip_load_q(ip_load_q), .nmi_service_q(nmi_service_q), .revision_word_q(revision_word_q)
);
`default_nettype wire

// >>> bench/irq_source_model.sv
/*
 model of the management interrupt sources: pin, controller message, nmi.
 assumes the testbench calls fire() between clock edges.
*/
`default_nettype none
module irq_source_model (
   // clock
   input wire logic core_clk,
   // request lines
   output logic mgmt_interrupt_pin_n,
   output logic mgmt_interrupt_msg,
   output logic nmi_req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {mgmt_interrupt_pin_n, mgmt_interrupt_msg, nmi_req} = 3'b100;
   end
   // pin held low long enough to pass the two-stage synchroniser
   task automatic fire(input int kind);
      @(posedge core_clk);
      case (kind)
         0: mgmt_interrupt_msg <= 1'b1;
         1: mgmt_interrupt_pin_n <= 1'b0;
         default: nmi_req <= 1'b1;
      endcase
      repeat (kind == 1 ? 6 : 1) @(posedge core_clk);
      {mgmt_interrupt_pin_n, mgmt_interrupt_msg, nmi_req} <= 3'b100;
   endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
/*
 testbench for the management mode save-area control block.
 assumes the source model drives the request lines; bench plays core and handler.
*/
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, srst, soft_init, maskable_irq, core_halted, resume_req, mem_ready;
   logic [31:0] saved_base_field, trapped_io_ip, next_io_ip, base;
   logic [7:0] io_restart_field;
   logic [15:0] halt_restart_field, seg_selector;
   wire mgmt_interrupt_pin_n, mgmt_interrupt_msg, nmi_req, mem_we, in_mgmt_mode_q, ip_load_q;
   wire reenter_halt_q, refetch_halt_q, halt_bus_cycle_q, wake_from_halt_q, nmi_service_q;
   wire [31:0] mem_addr, mem_wdata, save_area_base_q, instruction_pointer_q;
   wire [31:0] seg_base_q, revision_word_q;
   wire [15:0] code_seg_q;
   int n_mismatch, compares, n_wake, n_nmi, n_refetch, n_hbus;
   mgmt_mode_save_area_control dut_u (
      .core_clk(core_clk), .srst(srst), .soft_init(soft_init),
      .mgmt_interrupt_pin_n(mgmt_interrupt_pin_n), .mgmt_interrupt_msg(mgmt_interrupt_msg),
      .nmi_req(nmi_req), .maskable_irq(maskable_irq), .core_halted(core_halted),
      .resume_req(resume_req), .saved_base_field(saved_base_field),
      .io_restart_field(io_restart_field), .halt_restart_field(halt_restart_field),
      .seg_selector(seg_selector), .trapped_io_ip(trapped_io_ip), .next_io_ip(next_io_ip),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
      .in_mgmt_mode_q(in_mgmt_mode_q), .save_area_base_q(save_area_base_q),
      .code_seg_q(code_seg_q), .instruction_pointer_q(instruction_pointer_q),
      .seg_base_q(seg_base_q), .ip_load_q(ip_load_q), .reenter_halt_q(reenter_halt_q),
      .refetch_halt_q(refetch_halt_q), .halt_bus_cycle_q(halt_bus_cycle_q),
      .wake_from_halt_q(wake_from_halt_q), .nmi_service_q(nmi_service_q),
      .revision_word_q(revision_word_q)
   );
   irq_source_model src_u (
      .core_clk(core_clk), .mgmt_interrupt_pin_n(mgmt_interrupt_pin_n),
      .mgmt_interrupt_msg(mgmt_interrupt_msg), .nmi_req(nmi_req)
   );
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // one-cycle pulses are counted so a late check still sees them
   always @(posedge core_clk) begin
      n_wake += (wake_from_halt_q === 1'b1);
      n_nmi += (nmi_service_q === 1'b1);
      n_refetch += (refetch_halt_q === 1'b1);
      n_hbus += (halt_bus_cycle_q === 1'b1);
   end
   // ==========================================================
   // tasks
   task automatic close_out;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // 0: write pending, 1: handler start, 2: mode left
   task automatic wait_for(input int sel);
      int n;
      for (n = 0; n < 40; n++) begin
         tick(1);
         if ((sel == 0 && mem_we === 1'b1) || (sel == 1 && ip_load_q === 1'b1) ||
            (sel == 2 && in_mgmt_mode_q === 1'b0)) break;
      end
      cmp(n < 40, 1);
   endtask
   // kind 3: the request is already pending, nothing is fired
   task automatic entry(input int kind, input logic h, input int stall);
      @(posedge core_clk);
      core_halted <= h;
      if (kind < 3) begin
         src_u.fire(kind);
         core_halted <= 1'b0;
      end
      for (int i = 0; i < 3; i++) begin
         wait_for(0);
         cmp(mem_addr, base + (i == 0 ? 32'h7efc : i == 1 ? 32'h7f00 : 32'h7f02));
         cmp(mem_wdata, i == 0 ? 32'h00030001 : i == 1 ? 0 : {31'h0, h});
         repeat (stall) @(posedge core_clk);
         @(posedge core_clk);
         mem_ready <= 1'b1;
         @(posedge core_clk);
         mem_ready <= 1'b0;
      end
      wait_for(1);
      cmp(instruction_pointer_q, 32'h00008000);
      cmp(code_seg_q, base[19:4]);
   endtask
   task automatic resume(input logic [31:0] b, input logic [7:0] io, input logic h);
      @(posedge core_clk);
      saved_base_field <= b;
      io_restart_field <= io;
      halt_restart_field <= {15'h0, h};
      resume_req <= 1'b1;
      @(posedge core_clk);
      resume_req <= 1'b0;
      wait_for(2);
      cmp(save_area_base_q, b);
      base = b;
   endtask
   // ==========================================================
   // tests
   initial begin
      {srst, soft_init, maskable_irq, core_halted, resume_req, mem_ready} = 6'b100000;
      {saved_base_field, io_restart_field, halt_restart_field, seg_selector} = 0;
      trapped_io_ip = 32'h00001234;
      next_io_ip = 32'h00001236;
      base = 32'h00030000;
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      tick(2);
      cmp(save_area_base_q, 32'h00030000);
      cmp(revision_word_q, 32'h00030001);
      entry(0, 1'b0, 2);
      @(posedge core_clk);
      seg_selector <= 16'hbeef;
      core_halted <= 1'b1;
      tick(4);
      cmp(seg_base_q, 32'h000beef0);
      cmp(n_wake, 0);
      @(posedge core_clk);
      maskable_irq <= 1'b1;
      @(posedge core_clk);
      maskable_irq <= 1'b0;
      core_halted <= 1'b0;
      tick(3);
      cmp(n_wake, 1);
      resume(32'h00012344, 8'hff, 1'b0);
      cmp(instruction_pointer_q, trapped_io_ip);
      cmp(reenter_halt_q, 0);
      entry(1, 1'b1, 0);
      src_u.fire(2);
      src_u.fire(2);
      tick(3);
      cmp(n_nmi, 0);
      resume(32'h00012344, 8'h00, 1'b1);
      cmp(instruction_pointer_q, next_io_ip);
      tick(2);
      cmp(reenter_halt_q, 1);
      cmp(n_refetch, 1);
      cmp(n_hbus, 1);
      cmp(n_nmi, 1);
      @(posedge core_clk);
      soft_init <= 1'b1;
      @(posedge core_clk);
      soft_init <= 1'b0;
      tick(2);
      cmp(save_area_base_q, 32'h00012344);
      entry(0, 1'b0, 1);
      src_u.fire(0);
      resume(32'h00051238, 8'h00, 1'b0);
      cmp(instruction_pointer_q, next_io_ip);
      entry(3, 1'b0, 0);
      close_out;
   end
   initial begin
      #100000;
      n_mismatch++;
      close_out;
   end
endmodule
`default_nettype wire
